/* File: rtl/esrb_cfg.svh */
// register offsets, field positions, reset values and codes of the bank
`ifndef ESRB_CFG_SVH
`define ESRB_CFG_SVH
`define ESRB_OFS_IDENT      8'hD0
`define ESRB_OFS_SRST       8'hE0
`define ESRB_OFS_HUMCTL     8'hF2
`define ESRB_OFS_FLAGS      8'hF3
`define ESRB_OFS_ACQCTL     8'hF4
`define ESRB_OFS_CFG        8'hF5
`define ESRB_OFS_BARO_H     8'hF7
`define ESRB_OFS_BARO_M     8'hF8
`define ESRB_OFS_BARO_L     8'hF9
`define ESRB_OFS_THERM_H    8'hFA
`define ESRB_OFS_THERM_M    8'hFB
`define ESRB_OFS_THERM_L    8'hFC
`define ESRB_OFS_MOIST_H    8'hFD
`define ESRB_OFS_MOIST_L    8'hFE
`define ESRB_SRST_KEY       8'hB6
`define ESRB_RST_CTL        8'h00
`define ESRB_RST_BARO       20'h80000
`define ESRB_RST_MOIST      16'h8000
`define ESRB_FLAG_BUSY_BIT  3
`define ESRB_FLAG_COPY_BIT  0
`define ESRB_COPY_CYCLES    8'h10
`define ESRB_NOW_RATE_HZ    50000000
`endif

/* File: rtl/esrb_pkg.sv */
// types of the sensor register bank
package esrb_pkg;
    typedef enum logic [1:0]
    {
        ESRB_SLEEP  = 2'h0,
        ESRB_FORCED = 2'h1,
        ESRB_NORMAL = 2'h3
    } esrb_mode_type;
    typedef enum logic [1:0]
    {
        ESRB_ST_IDLE = 2'h0,
        ESRB_ST_COPY = 2'h1,
        ESRB_ST_CONV = 2'h3,
        ESRB_ST_WAIT = 2'h2
    } esrb_state_type;
endpackage

/* File: rtl/esrb_standby_timer.sv */
// standby timer that times the gap between normal-mode cycles
`include "esrb_cfg.svh"
module esrb_standby_timer
    import esrb_pkg::*;
#(
    parameter int unsigned TICK_DIV = 25000
)
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_start,
    input  wire logic [2:0] i_sel,
    output logic            o_done
);
    // ========================================================
    // half-millisecond tick and count of ticks
    logic [15:0] div_q;
    logic [11:0] cnt_q;
    logic        run_q;
    logic        tick;
    logic [11:0] limit;
    assign tick = (div_q == 16'(TICK_DIV - 1));
    // standby length in 0.5 ms steps
    always_comb
    begin
        case (i_sel)
            3'h0:    limit = 12'h001;
            3'h1:    limit = 12'h07D;
            3'h2:    limit = 12'h0FA;
            3'h3:    limit = 12'h1F4;
            3'h4:    limit = 12'h3E8;
            3'h5:    limit = 12'h7D0;
            3'h6:    limit = 12'h014;
            default: limit = 12'h028;
        endcase
    end
    // divider and counter
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_q  <= 16'h0000;
            cnt_q  <= 12'h000;
            run_q  <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start)
            begin
                div_q <= 16'h0000;
                cnt_q <= 12'h000;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                div_q <= tick ? 16'h0000 : div_q + 16'h0001;
                if (tick)
                begin
                    if (cnt_q + 12'h001 >= limit)
                    begin
                        run_q  <= 1'b0;
                        o_done <= 1'b1;
                    end
                    cnt_q <= cnt_q + 12'h001;
                end
            end
        end
    end
endmodule // esrb_standby_timer

/* File: rtl/esrb_bank.sv */
// register bank of the humidity, pressure and temperature sensor
`include "esrb_cfg.svh"
// Operation
// RQ1: identification byte readable right after reset
// RQ2: key 0xB6 to reset word resets all
// RQ3: other values to reset word ignored
// RQ4: reset word always reads zero
// RQ5: humidity setting applies on acquisition write
// RQ6: humidity code 000 skips, gives 0x8000
// RQ7: busy flag while converting until results stored
// RQ8: copy flag during image copy, before conversions
// RQ9: acquisition fields temp, pressure, mode
// RQ10: pressure/temperature code 000 skips, 0x80000
// RQ11: mode 00 sleep, 01/10 forced, 11 normal
// RQ12: config writes ignored in normal mode
// RQ13: standby select sets normal-mode gap
// RQ14: filter select decodes off,2,4,8,16
// RQ15: config bit 0 selects three-wire interface
// RQ16: pressure result split over three bytes
// RQ17: temperature result split over three bytes
// RQ18: humidity result split over two bytes
// RQ19: all registers eight bits wide
// RQ20: unused bits read zero, ignore writes
module esrb_bank
    import esrb_pkg::*;
#(
    parameter logic [7:0]  IDENT_VALUE = 8'h5A, // arbitrary value
    parameter int unsigned TICK_DIV    = 25000
)
(
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_res_valid,
    input  wire logic [19:0] i_raw_baro,
    input  wire logic [19:0] i_raw_temperature_word,
    input  wire logic [15:0] i_raw_humidity_word,
    output logic [7:0]       o_rdata,
    output logic             o_conv_start,
    output logic [2:0]       o_os_hum,
    output logic [2:0]       o_os_baro,
    output logic [2:0]       o_os_therm,
    output logic [2:0]       o_filter_coef,
    output logic             o_three_wire_select
);
    // ========================================================
    // soft reset and register storage
    logic          srst;
    logic [2:0]    humctl_q;
    logic [2:0]    hum_live_q;
    logic [7:0]    acq_q;
    logic [7:0]    cfg_q;
    logic [19:0]   baro_q;
    logic [19:0]   therm_q;
    logic [15:0]   moist_q;
    esrb_state_type st_q;
    logic [7:0]    copy_cnt_q;
    logic          busy_flag_q;
    logic          image_copy_flag_q;
    logic          sb_done;
    logic          sb_start;
    logic          acq_wr;
    esrb_mode_type mode;
    // key write performs the full reset; other values ignored
    assign srst = i_wr && i_addr == `ESRB_OFS_SRST
               && i_wdata == `ESRB_SRST_KEY; // RQ2 RQ3
    assign acq_wr = i_wr && i_addr == `ESRB_OFS_ACQCTL;
    // mode 01 and 10 both forced
    always_comb
    begin
        case (acq_q[1:0]) // RQ11
            2'h0:    mode = ESRB_SLEEP;
            2'h3:    mode = ESRB_NORMAL;
            default: mode = ESRB_FORCED;
        endcase
    end

    // ========================================================
    // control registers
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            humctl_q   <= 3'h0;
            hum_live_q <= 3'h0;
            acq_q      <= `ESRB_RST_CTL;
            cfg_q      <= `ESRB_RST_CTL;
        end
        else if (srst)
        begin
            humctl_q   <= 3'h0;
            hum_live_q <= 3'h0;
            acq_q      <= `ESRB_RST_CTL;
            cfg_q      <= `ESRB_RST_CTL;
        end
        else if (i_wr)
        begin
            if (i_addr == `ESRB_OFS_HUMCTL)
                humctl_q <= i_wdata[2:0]; // RQ20
            if (acq_wr)
            begin
                acq_q      <= i_wdata; // RQ9
                hum_live_q <= humctl_q; // RQ5
            end
            if (i_addr == `ESRB_OFS_CFG && mode != ESRB_NORMAL)
                cfg_q <= {i_wdata[7:2], 1'b0, i_wdata[0]}; // RQ12 RQ20
        end
    end
    // checks of the control registers
    sequence s_key_write;
        i_wr && i_addr == `ESRB_OFS_SRST && i_wdata == `ESRB_SRST_KEY;
    endsequence
    a_key_reset: assert property ( // RQ2
        @(posedge i_clk) disable iff (!i_arst_n)
        s_key_write |=> acq_q == 8'h00 && image_copy_flag_q)
        else $error("key write did not reset");
    a_nonkey_keep: assert property ( // RQ3
        @(posedge i_clk) disable iff (!i_arst_n)
        i_wr && i_addr == `ESRB_OFS_SRST && i_wdata != `ESRB_SRST_KEY
        |=> $stable(acq_q) && $stable(cfg_q))
        else $error("non-key write changed state");
    a_hum_deferred: assert property ( // RQ5
        @(posedge i_clk) disable iff (!i_arst_n)
        !acq_wr && !srst |=> $stable(hum_live_q))
        else $error("humidity setting applied early");
    a_cfg_normal: assert property ( // RQ12
        @(posedge i_clk) disable iff (!i_arst_n)
        i_wr && i_addr == `ESRB_OFS_CFG && mode == ESRB_NORMAL
        |=> $stable(cfg_q))
        else $error("config written in normal mode");

    // ========================================================
    // copy and conversion sequencer
    assign sb_start = (st_q == ESRB_ST_CONV) && i_res_valid
                   && mode == ESRB_NORMAL;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_q              <= ESRB_ST_COPY;
            copy_cnt_q        <= 8'h00;
            busy_flag_q       <= 1'b0;
            image_copy_flag_q <= 1'b1;
            o_conv_start      <= 1'b0;
        end
        else if (srst)
        begin
            st_q              <= ESRB_ST_COPY;
            copy_cnt_q        <= 8'h00;
            busy_flag_q       <= 1'b0;
            image_copy_flag_q <= 1'b1; // RQ8
            o_conv_start      <= 1'b0;
        end
        else
        begin
            o_conv_start <= 1'b0;
            case (st_q)
                ESRB_ST_IDLE:
                begin
                    if (acq_wr && i_wdata[1:0] != 2'h0)
                    begin
                        st_q              <= ESRB_ST_COPY;
                        copy_cnt_q        <= 8'h00;
                        image_copy_flag_q <= 1'b1; // RQ8
                        busy_flag_q       <= 1'b1; // RQ7
                    end
                end
                ESRB_ST_COPY:
                begin
                    copy_cnt_q <= copy_cnt_q + 8'h01;
                    if (copy_cnt_q == `ESRB_COPY_CYCLES - 8'h01)
                    begin
                        image_copy_flag_q <= 1'b0; // RQ8
                        if (busy_flag_q)
                        begin
                            st_q         <= ESRB_ST_CONV;
                            o_conv_start <= 1'b1;
                        end
                        else
                            st_q <= ESRB_ST_IDLE;
                    end
                end
                ESRB_ST_CONV:
                begin
                    if (i_res_valid)
                    begin
                        busy_flag_q <= 1'b0; // RQ7
                        if (mode == ESRB_NORMAL)
                            st_q <= ESRB_ST_WAIT;
                        else
                        begin
                            st_q  <= ESRB_ST_IDLE;
                        end
                    end
                end
                ESRB_ST_WAIT:
                begin
                    if (mode != ESRB_NORMAL)
                        st_q <= ESRB_ST_IDLE;
                    else if (sb_done)
                    begin
                        st_q              <= ESRB_ST_COPY;
                        copy_cnt_q        <= 8'h00;
                        image_copy_flag_q <= 1'b1;
                        busy_flag_q       <= 1'b1;
                    end
                end
                default: st_q <= ESRB_ST_IDLE;
            endcase
        end
    end
    // forced mode keeps its 01/10 code in acq_q after its one cycle
    // the sequencer returns to idle until the next acquisition write
    // checks of the copy and conversion sequencer
    a_busy_clear: assert property ( // RQ7
        @(posedge i_clk) disable iff (!i_arst_n)
        st_q == ESRB_ST_CONV && i_res_valid && !srst
        |=> !busy_flag_q && st_q != ESRB_ST_CONV)
        else $error("busy flag stuck");
    a_busy_in_conv: assert property ( // RQ7
        @(posedge i_clk) disable iff (!i_arst_n)
        st_q == ESRB_ST_CONV |-> busy_flag_q)
        else $error("busy flag low while converting");
    a_copy_len: assert property ( // RQ8
        @(posedge i_clk) disable iff (!i_arst_n)
        $rose(image_copy_flag_q) |-> image_copy_flag_q [*8])
        else $error("copy flag too short");
    a_conv_after_copy: assert property ( // RQ8
        @(posedge i_clk) disable iff (!i_arst_n)
        o_conv_start |-> st_q == ESRB_ST_CONV && !image_copy_flag_q)
        else $error("conversion started before image copy ended");

    // standby gap between normal-mode cycles
    esrb_standby_timer #(
        .TICK_DIV (TICK_DIV)
    ) u_standby (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_start  (sb_start),
        .i_sel    (cfg_q[7:5]), // RQ13
        .o_done   (sb_done)
    );

    // ========================================================
    // result registers, skipped channels forced to midscale
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            baro_q  <= `ESRB_RST_BARO;
            therm_q <= `ESRB_RST_BARO;
            moist_q <= `ESRB_RST_MOIST;
        end
        else if (srst)
        begin
            baro_q  <= `ESRB_RST_BARO;
            therm_q <= `ESRB_RST_BARO;
            moist_q <= `ESRB_RST_MOIST;
        end
        else if (st_q == ESRB_ST_CONV && i_res_valid)
        begin
            baro_q  <= (acq_q[4:2] == 3'h0) ? `ESRB_RST_BARO
                                           : i_raw_baro; // RQ10
            therm_q <= (acq_q[7:5] == 3'h0) ? `ESRB_RST_BARO
                                           : i_raw_temperature_word;
            moist_q <= (hum_live_q == 3'h0) ? `ESRB_RST_MOIST
                                           : i_raw_humidity_word; // RQ6
        end
    end
    // check of a skipped pressure channel
    a_skip_mid: assert property ( // RQ10
        @(posedge i_clk) disable iff (!i_arst_n)
        st_q == ESRB_ST_CONV && i_res_valid && acq_q[4:2] == 3'h0
        |=> baro_q == `ESRB_RST_BARO)
        else $error("skipped pressure not midscale");

    // ========================================================
    // decoded settings to the measurement engine
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_os_hum            <= 3'h0;
            o_os_baro           <= 3'h0;
            o_os_therm          <= 3'h0;
            o_filter_coef       <= 3'h0;
            o_three_wire_select <= 1'b0;
        end
        else
        begin
            // codes above 101 clamp to x16 (code 101)
            o_os_hum   <= (hum_live_q > 3'h5) ? 3'h5 : hum_live_q; // RQ6
            o_os_baro  <= (acq_q[4:2] > 3'h5) ? 3'h5
                                             : acq_q[4:2]; // RQ10
            o_os_therm <= (acq_q[7:5] > 3'h5) ? 3'h5
                                             : acq_q[7:5]; // RQ10
            // codes above 100 clamp to coefficient 16
            o_filter_coef <= (cfg_q[4:2] > 3'h4) ? 3'h4
                                                : cfg_q[4:2]; // RQ14
            o_three_wire_select <= cfg_q[0]; // RQ15
        end
    end

    // ========================================================
    // read mux, registered
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr) // RQ19
                `ESRB_OFS_IDENT:   o_rdata <= IDENT_VALUE; // RQ1
                `ESRB_OFS_SRST:    o_rdata <= 8'h00; // RQ4
                `ESRB_OFS_HUMCTL:  o_rdata <= {5'h00, humctl_q}; // RQ20
                `ESRB_OFS_FLAGS:   o_rdata <= {4'h0, busy_flag_q, 2'h0,
                                              image_copy_flag_q};
                `ESRB_OFS_ACQCTL:  o_rdata <= acq_q;
                `ESRB_OFS_CFG:     o_rdata <= cfg_q;
                `ESRB_OFS_BARO_H:  o_rdata <= baro_q[19:12]; // RQ16
                `ESRB_OFS_BARO_M:  o_rdata <= baro_q[11:4];
                `ESRB_OFS_BARO_L:  o_rdata <= {baro_q[3:0], 4'h0};
                `ESRB_OFS_THERM_H: o_rdata <= therm_q[19:12]; // RQ17
                `ESRB_OFS_THERM_M: o_rdata <= therm_q[11:4];
                `ESRB_OFS_THERM_L: o_rdata <= {therm_q[3:0], 4'h0};
                `ESRB_OFS_MOIST_H: o_rdata <= moist_q[15:8]; // RQ18
                `ESRB_OFS_MOIST_L: o_rdata <= moist_q[7:0];
                default:           o_rdata <= 8'h00;
            endcase
        end
    end

    // ========================================================
    // checks of the read path
    a_ident_read: assert property ( // RQ1
        @(posedge i_clk) disable iff (!i_arst_n)
        i_rd && i_addr == `ESRB_OFS_IDENT |=> o_rdata == IDENT_VALUE)
        else $error("identification byte wrong");
    a_srst_reads0: assert property ( // RQ4
        @(posedge i_clk) disable iff (!i_arst_n)
        i_rd && i_addr == `ESRB_OFS_SRST |=> o_rdata == 8'h00)
        else $error("reset word read nonzero");
    a_nibble_zero: assert property ( // RQ20
        @(posedge i_clk) disable iff (!i_arst_n)
        i_rd && i_addr == `ESRB_OFS_BARO_L |=> o_rdata[3:0] == 4'h0)
        else $error("low nibble not zero");
endmodule // esrb_bank

/* File: verification/esrb_engine_model.sv */
// measurement engine model answering conversion requests
module esrb_engine_model
#(
    parameter logic [19:0] BARO  = 20'hABCDE,
    parameter logic [19:0] THERM = 20'h12345,
    parameter logic [15:0] MOIST = 16'hBEEF
)
(
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_start,
    input  wire logic [7:0] i_delay,
    output logic            o_valid,
    output logic [19:0]     o_baro,
    output logic [19:0]     o_therm,
    output logic [15:0]     o_moist,
    output logic [7:0]      o_starts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  cnt_q    = 8'h00;
    logic        busy_q   = 1'b0;
    logic        valid_q  = 1'b0;
    logic [7:0]  starts_q = 8'h00;
    logic [19:0] noise_q  = 20'h5A5A5;
    // counts down the conversion time, then pulses valid once
    always @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            busy_q   <= 1'b0;
            valid_q  <= 1'b0;
            starts_q <= 8'h00;
        end
        else
        begin
            noise_q <= ~{noise_q[18:0], noise_q[19]};
            valid_q <= 1'b0;
            if (i_start)
            begin
                busy_q   <= 1'b1;
                cnt_q    <= i_delay;
                starts_q <= starts_q + 8'h01;
            end
            else if (busy_q && cnt_q == 8'h00)
            begin
                busy_q  <= 1'b0;
                valid_q <= 1'b1;
            end
            else if (busy_q)
                cnt_q <= cnt_q - 8'h01;
        end
    end
    // results carry meaning only in the valid cycle
    assign o_valid  = valid_q;
    assign o_starts = starts_q;
    assign o_baro   = valid_q ? BARO : noise_q;
    assign o_therm  = valid_q ? THERM : ~noise_q;
    assign o_moist  = valid_q ? MOIST : noise_q[15:0];
endmodule // esrb_engine_model

/* File: verification/tb_top.sv */
// testbench of the sensor register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] BARO  = 20'hABCDE;
    localparam logic [19:0] THERM = 20'h12345;
    localparam logic [15:0] MOIST = 16'hBEEF;
    localparam int          TICK  = 4;
    logic        clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, delay = 8'h00, rdata, starts;
    logic [2:0]  os_h, os_b, os_t, filt;
    logic        conv, three_w, res_v;
    logic [19:0] raw_b, raw_t;
    logic [15:0] raw_h;
    int          fail_count = 0, n_compared = 0, cyc = 0;
    // ==========================================================
    // clock and instances
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    esrb_bank #(.IDENT_VALUE(8'h5A), .TICK_DIV(TICK)) i_dut
    (
        .i_clk(clk), .i_arst_n(arst_n), .i_wr(wr_s), .i_rd(rd_s),
        .i_addr(addr), .i_wdata(wdata), .i_res_valid(res_v),
        .i_raw_baro(raw_b), .i_raw_temperature_word(raw_t),
        .i_raw_humidity_word(raw_h), .o_rdata(rdata),
        .o_conv_start(conv), .o_os_hum(os_h), .o_os_baro(os_b),
        .o_os_therm(os_t), .o_filter_coef(filt),
        .o_three_wire_select(three_w)
    );
    esrb_engine_model #(.BARO(BARO), .THERM(THERM), .MOIST(MOIST)) i_eng
    (
        .i_clk(clk), .i_arst_n(arst_n), .i_start(conv), .i_delay(delay),
        .o_valid(res_v), .o_baro(raw_b), .o_therm(raw_t),
        .o_moist(raw_h), .o_starts(starts)
    );
    // ==========================================================
    // checking and access tasks
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] lim(input int c, input int m);
        return (c > m) ? m[7:0] : c[7:0];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask
    task automatic chk_res(input logic [19:0] b, input logic [19:0] t,
                           input logic [15:0] m);
        logic [7:0] e [8];
        e = '{b[19:12], b[11:4], {b[3:0], 4'h0}, t[19:12], t[11:4],
              {t[3:0], 4'h0}, m[15:8], m[7:0]};
        for (int i = 0; i < 8; i++)
            rchk("result byte", 8'hF7 + i[7:0], e[i]);
    endtask
    task automatic wait_idle;
        logic [7:0] v;
        int k;
        v = 8'hFF;
        for (k = 0; k < 300 && (v & 8'h09) !== 8'h00; k++)
            rd(8'hF3, v);
        if ((v & 8'h09) !== 8'h00)
        begin
            fail_count++;
            $display("mismatch status idle expected 00 seen %h", v);
            test_done;
        end
    endtask
    task automatic wait_starts(input logic [7:0] n, output int t);
        int k;
        for (k = 0; k < 20000 && starts !== n; k++)
            @(posedge clk);
        t = cyc;
        if (starts !== n)
        begin
            fail_count++;
            $display("mismatch starts expected %h seen %h", n, starts);
            test_done;
        end
    endtask
    // ==========================================================
    // test sequence
    logic [7:0] f_hum [4] = '{8'h01, 8'h02, 8'h01, 8'h00};
    logic [7:0] f_acq [4] = '{8'h25, 8'h4A, 8'h21, 8'h05};
    logic [7:0] f_dly [4] = '{8'h00, 8'h28, 8'h05, 8'h05};
    logic [2:0] sel [2] = '{3'h0, 3'h6};
    int         gap [2];
    int         t1, t2, prev;
    logic [7:0] s0;
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rchk("ident", 8'hD0, 8'h5A);
        rchk("status", 8'hF3, 8'h01);
        rchk("reset word", 8'hE0, 8'h00);
        rchk("unmapped", 8'hF6, 8'h00);
        wait_idle;
        chk_res(20'h80000, 20'h80000, 16'h8000);
        $display("test reset state done");
        prev = 0;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'hF2, {5'h1F, c[2:0]});
            repeat (3) @(posedge clk);
            chk("hum held", lim(prev, 5), {5'h0, os_h});
            wr(8'hF4, {c[2:0], c[2:0], 2'b00});
            prev = c;
            repeat (3) @(posedge clk);
            chk("hum os", lim(c, 5), {5'h0, os_h});
            chk("baro os", lim(c, 5), {5'h0, os_b});
            chk("therm os", lim(c, 5), {5'h0, os_t});
            rchk("hum ctl", 8'hF2, {5'h0, c[2:0]});
            rchk("acq", 8'hF4, {c[2:0], c[2:0], 2'b00});
            wr(8'hF5, {c[2:0], c[2:0], 1'b1, c[0]});
            repeat (3) @(posedge clk);
            chk("filter", lim(c, 4), {5'h0, filt});
            chk("three wire", {7'h0, c[0]}, {7'h0, three_w});
            rchk("cfg", 8'hF5, {c[2:0], c[2:0], 1'b0, c[0]});
        end
        chk("sleep starts", 8'h00, starts);
        $display("test settings done");
        for (int i = 0; i < 4; i++)
        begin
            delay <= f_dly[i];
            s0 = starts;
            wr(8'hF2, f_hum[i]);
            wr(8'hF4, f_acq[i]);
            rchk("busy copy", 8'hF3, 8'h09);
            wait_idle;
            repeat (50) @(posedge clk);
            chk("forced starts", s0 + 8'h01, starts);
            chk_res(f_acq[i][4:2] == 3'h0 ? 20'h80000 : BARO,
                    f_acq[i][7:5] == 3'h0 ? 20'h80000 : THERM,
                    f_hum[i][2:0] == 3'h0 ? 16'h8000 : MOIST);
        end
        $display("test forced done");
        for (int i = 0; i < 2; i++)
        begin
            wr(8'hF5, {sel[i], 5'h00});
            wr(8'hF4, 8'h27);
            s0 = starts;
            wait_starts(s0 + 8'h02, t1);
            wait_starts(s0 + 8'h03, t2);
            gap[i] = t2 - t1;
            wr(8'hF5, 8'hFD);
            rchk("cfg in normal", 8'hF5, {sel[i], 5'h00});
            wr(8'hF4, 8'h24);
            wait_idle;
        end
        chk("standby gap", 8'(gap[1] - gap[0]), 8'(19 * TICK));
        $display("test normal done");
        wr(8'hF2, 8'h03);
        wr(8'hF5, 8'hA0);
        wr(8'hE0, 8'h12);
        rchk("acq kept", 8'hF4, 8'h24);
        rchk("cfg kept", 8'hF5, 8'hA0);
        rchk("reset word", 8'hE0, 8'h00);
        wr(8'hF7, 8'h55);
        rchk("ro byte", 8'hF7, BARO[19:12]);
        wr(8'hE0, 8'hB6);
        rchk("status", 8'hF3, 8'h01);
        rchk("ident", 8'hD0, 8'h5A);
        rchk("hum ctl", 8'hF2, 8'h00);
        rchk("acq", 8'hF4, 8'h00);
        rchk("cfg", 8'hF5, 8'h00);
        chk_res(20'h80000, 20'h80000, 16'h8000);
        $display("test soft reset done");
        test_done;
    end
endmodule // tb_top
